/* File: src/slsc_sync_ctrl.sv */
// Operation
// - mode 0 sends CRC-12, mode 2 sends FEC; 1 and 3 reserved
// - sync-header mode acts only when a 64B/66B format is selected
// - each multi-block, while enabled in a 64B/66B format, carries one 32-bit sync word built from headers
// - command fields are always zero, giving idle headers
// - the active-low sync input is sampled by the link clock
// - sync low for threshold plus one consecutive samples, and at least two, is a request
// - shorter low runs of two or more samples count as error reports and are otherwise ignored
// - threshold is five bits, bits 4 to 0, reset value 3
// - status bit shows sync level: 0 asserted, 1 deasserted
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "slsc_defs.svh"

module slsc_sync_ctrl
(
   // clock, reset, enable
   input  wire logic        i_sys_clk,
   input  wire logic        i_rst,
   input  wire logic        i_clk_en,
   // axi4-lite write address
   input  wire logic [13:0] i_s_axi_awaddr,
   input  wire logic        i_s_axi_awvalid,
   output logic             o_s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0] i_s_axi_wdata,
   input  wire logic [3:0]  i_s_axi_wstrb,
   input  wire logic        i_s_axi_wvalid,
   output logic             o_s_axi_wready,
   // axi4-lite write response
   output logic [1:0]       o_s_axi_bresp,
   output logic             o_s_axi_bvalid,
   input  wire logic        i_s_axi_bready,
   // axi4-lite read address
   input  wire logic [13:0] i_s_axi_araddr,
   input  wire logic        i_s_axi_arvalid,
   output logic             o_s_axi_arready,
   // axi4-lite read data
   output logic [31:0]      o_s_axi_rdata,
   output logic [1:0]       o_s_axi_rresp,
   output logic             o_s_axi_rvalid,
   input  wire logic        i_s_axi_rready,
   // sync request pin from the receiver
   input  wire logic        i_sync_req_n,
   // multi-block boundary and header payloads
   input  wire logic        i_mb_start,
   input  wire logic [11:0] i_crc12,
   input  wire logic [25:0] i_fec,
   // link control outputs
   output logic             o_send_cgs,
   output logic             o_sync_request,
   output logic [31:0]      o_sync_word,
   output logic             o_sync_word_valid
);

   // -------------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------------
   function automatic logic [11:0] reg_index(input logic [13:0] addr);
      reg_index = addr[13:2];
   endfunction : reg_index

   function automatic logic is_mapped(input logic [11:0] idx);
      is_mapped = (idx == `SLSC_IDX_CTRL) || (idx == `SLSC_IDX_STATUS)
                  || (idx == `SLSC_IDX_SYNC_HEADER_MODE)
                  || (idx == `SLSC_IDX_THRESH);
   endfunction : is_mapped

   function automatic logic fmt_is_6466(input logic [3:0] fmt);
      fmt_is_6466 = fmt[`SLSC_FMT_6466_BIT];
   endfunction : fmt_is_6466

   // -------------------------------------------------------------------
   // sync input filter
   // -------------------------------------------------------------------
   slsc_pkg::slsc_st_t q;
   slsc_pkg::slsc_st_t d;
   logic               flt_level;
   logic               flt_request;
   logic               flt_error;

   slsc_sync_filter u_filter
   (
      .i_sys_clk    (i_sys_clk),
      .i_rst        (i_rst),
      .i_clk_en     (i_clk_en),
      .i_sync_req_n (i_sync_req_n),
      .i_thresh     (q.thresh),
      .o_level      (flt_level),
      .o_request    (flt_request),
      .o_error      (flt_error)
   );

   // -------------------------------------------------------------------
   // next state
   // -------------------------------------------------------------------
   logic        do_write;
   logic [11:0] w_idx;
   logic [11:0] r_idx;
   logic        status_clr;
   logic [31:0] rd_word;

   always_comb
   begin
      d          = q;
      do_write   = q.aw_have && q.w_have && !q.bvalid;
      w_idx      = reg_index(q.aw_addr);
      r_idx      = reg_index(i_s_axi_araddr);
      status_clr = 1'b0;
      rd_word    = 32'h0000_0000;

      // write address and data are taken independently, in any order
      if (i_s_axi_awvalid && q.awready)
      begin
         d.aw_addr = i_s_axi_awaddr;
         d.aw_have = 1'b1;
      end
      if (i_s_axi_wvalid && q.wready)
      begin
         d.w_data = i_s_axi_wdata;
         d.w_strb = i_s_axi_wstrb;
         d.w_have = 1'b1;
      end
      d.awready = !d.aw_have;
      d.wready  = !d.w_have;

      if (do_write)
      begin
         d.aw_have = 1'b0;
         d.w_have  = 1'b0;
         d.awready = 1'b1;
         d.wready  = 1'b1;
         d.bvalid  = 1'b1;
         d.bresp   = is_mapped(w_idx) ? `SLSC_RESP_OKAY
                                      : `SLSC_RESP_SLVERR;
         if (q.w_strb[0])
         begin
            case (w_idx)
               `SLSC_IDX_CTRL:
               begin
                  d.tx_en = q.w_data[`SLSC_CTRL_EN_BIT];
                  d.fmt   = q.w_data[`SLSC_CTRL_FMT_LSB +: 4];
               end
               `SLSC_IDX_STATUS:
               begin
                  status_clr = 1'b1;
               end
               `SLSC_IDX_SYNC_HEADER_MODE:
               begin
                  // only the field is stored; upper bits read zero
                  if (!q.tx_en)
                  begin
                     d.sync_header_mode = q.w_data[1:0];
                  end
               end
               `SLSC_IDX_THRESH:
               begin
                  if (!q.tx_en)
                  begin
                     d.thresh = q.w_data[4:0];
                  end
               end
               default:
               begin
                  status_clr = 1'b0;
               end
            endcase
         end
      end
      else if (q.bvalid && i_s_axi_bready)
      begin
         d.bvalid = 1'b0;
      end

      // error reports are only counted; a new one beats the clear
      if (flt_error)
      begin
         d.err_cnt = status_clr ? 8'h01
                   : (q.err_cnt == `SLSC_ERRCNT_MAX) ? q.err_cnt
                   : q.err_cnt + 8'h01;
      end
      else if (status_clr)
      begin
         d.err_cnt = 8'h00;
      end

      // read channel: one read in flight, data held until rready
      case (r_idx)
         `SLSC_IDX_CTRL:
         begin
            rd_word[`SLSC_CTRL_EN_BIT]       = q.tx_en;
            rd_word[`SLSC_CTRL_FMT_LSB +: 4] = q.fmt;
         end
         `SLSC_IDX_STATUS:
         begin
            rd_word[`SLSC_ST_LEVEL_BIT]        = flt_level;
            rd_word[`SLSC_ST_REQ_BIT]          = flt_request;
            rd_word[`SLSC_ST_CGS_BIT]          = q.send_cgs;
            rd_word[`SLSC_ST_ERRCNT_LSB +: 8]  = q.err_cnt;
         end
         `SLSC_IDX_SYNC_HEADER_MODE:
         begin
            rd_word[1:0] = q.sync_header_mode;
         end
         `SLSC_IDX_THRESH:
         begin
            rd_word[4:0] = q.thresh;
         end
         default:
         begin
            rd_word = 32'h0000_0000;
         end
      endcase
      if (i_s_axi_arvalid && q.arready)
      begin
         d.arready = 1'b0;
         d.rvalid  = 1'b1;
         d.rdata   = rd_word;
         d.rresp   = is_mapped(r_idx) ? `SLSC_RESP_OKAY
                                      : `SLSC_RESP_SLVERR;
      end
      else if (q.rvalid && i_s_axi_rready)
      begin
         d.rvalid  = 1'b0;
         d.arready = 1'b1;
      end

      // link control: code group sync only exists in 8B/10B formats
      case (q.link)
         slsc_pkg::SLSC_LS_OFF:
         begin
            if (q.tx_en)
            begin
               d.link = (flt_request && !fmt_is_6466(q.fmt))
                        ? slsc_pkg::SLSC_LS_CGS : slsc_pkg::SLSC_LS_RUN;
            end
         end
         slsc_pkg::SLSC_LS_RUN:
         begin
            if (!q.tx_en)
            begin
               d.link = slsc_pkg::SLSC_LS_OFF;
            end
            else if (flt_request && !fmt_is_6466(q.fmt))
            begin
               d.link = slsc_pkg::SLSC_LS_CGS;
            end
         end
         slsc_pkg::SLSC_LS_CGS:
         begin
            if (!q.tx_en)
            begin
               d.link = slsc_pkg::SLSC_LS_OFF;
            end
            else if (flt_level)
            begin
               d.link = slsc_pkg::SLSC_LS_RUN;
            end
         end
         default:
         begin
            d.link = slsc_pkg::SLSC_LS_OFF;
         end
      endcase
      d.send_cgs = (d.link == slsc_pkg::SLSC_LS_CGS);
      // one edge behind the filter, so it rises in step with cgs; on release cgs drops one edge earlier
      d.sync_request = flt_request;

      // sync word, one per multi-block, command fields left at zero
      d.sync_word_valid = 1'b0;
      if (i_mb_start && q.tx_en && fmt_is_6466(q.fmt))
      begin
         d.sync_word_valid = 1'b1;
         d.sync_word       = 32'h0000_0000;
         case (q.sync_header_mode)
            `SLSC_SHM_CRC:
            begin
               d.sync_word[`SLSC_SW_CRC_LSB +: 12] = i_crc12;
            end
            `SLSC_SHM_FEC:
            begin
               d.sync_word[`SLSC_SW_FEC_LSB +: 26] = i_fec;
            end
            default:
            begin
               // reserved modes send idle headers only
               d.sync_word = 32'h0000_0000;
            end
         endcase
      end
   end

   // -------------------------------------------------------------------
   // state register
   // -------------------------------------------------------------------
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         q                 <= '0;
         q.awready         <= 1'b1;
         q.wready          <= 1'b1;
         q.arready         <= 1'b1;
         q.fmt             <= `SLSC_RST_FMT;
         q.sync_header_mode          <= `SLSC_RST_SYNC_HEADER_MODE;
         q.thresh          <= `SLSC_RST_THRESH;
         q.link            <= slsc_pkg::SLSC_LS_OFF;
      end
      else if (i_clk_en)
      begin
         q <= d;
      end
   end

   // -------------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------------
   assign o_s_axi_awready   = q.awready;
   assign o_s_axi_wready    = q.wready;
   assign o_s_axi_bvalid    = q.bvalid;
   assign o_s_axi_bresp     = q.bresp;
   assign o_s_axi_arready   = q.arready;
   assign o_s_axi_rvalid    = q.rvalid;
   assign o_s_axi_rdata     = q.rdata;
   assign o_s_axi_rresp     = q.rresp;
   assign o_send_cgs        = q.send_cgs;
   assign o_sync_request    = q.sync_request;
   assign o_sync_word       = q.sync_word;
   assign o_sync_word_valid = q.sync_word_valid;

endmodule : slsc_sync_ctrl

`default_nettype wire

/* File: src/slsc_defs.svh */
`ifndef SLSC_DEFS_SVH
`define SLSC_DEFS_SVH

// ----------------------------------------------------------------------
// register map: indices, byte address is four times the index
// ----------------------------------------------------------------------
`define SLSC_ADDR_W          14
`define SLSC_IDX_CTRL        12'h200
`define SLSC_IDX_STATUS      12'h208
`define SLSC_IDX_SYNC_HEADER_MODE      12'h20F
`define SLSC_IDX_THRESH      12'h210

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define SLSC_RST_SYNC_HEADER_MODE      2'h0
`define SLSC_RST_THRESH      5'h03
`define SLSC_RST_FMT         4'h0

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define SLSC_CTRL_EN_BIT     0
`define SLSC_CTRL_FMT_LSB    4
`define SLSC_FMT_6466_BIT    3
`define SLSC_ST_LEVEL_BIT    0
`define SLSC_ST_REQ_BIT      1
`define SLSC_ST_CGS_BIT      2
`define SLSC_ST_ERRCNT_LSB   8

// ----------------------------------------------------------------------
// sync-header modes, sync word layout, bus answers
// ----------------------------------------------------------------------
`define SLSC_SHM_CRC         2'h0
`define SLSC_SHM_FEC         2'h2
`define SLSC_SW_CRC_LSB      20
`define SLSC_SW_FEC_LSB      6
`define SLSC_RESP_OKAY       2'h0
`define SLSC_RESP_SLVERR     2'h2
`define SLSC_LOWCNT_MAX      6'h3F
`define SLSC_ERRCNT_MAX      8'hFF

`endif

/* File: src/slsc_pkg.sv */
package slsc_pkg;

   typedef enum logic [1:0] {
      SLSC_LS_OFF,
      SLSC_LS_CGS,
      SLSC_LS_RUN
   } slsc_link_t;

   typedef struct packed {
      logic       s1;
      logic       s2;
      logic       s3;
      logic       level;
      logic [5:0] low_cnt;
      logic       request;
      logic       error;
   } slsc_flt_st_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic [13:0] aw_addr;
      logic        aw_have;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        w_have;
      logic        tx_en;
      logic [3:0]  fmt;
      logic [1:0]  sync_header_mode;
      logic [4:0]  thresh;
      logic [7:0]  err_cnt;
      slsc_link_t  link;
      logic        send_cgs;
      logic        sync_request;
      logic [31:0] sync_word;
      logic        sync_word_valid;
   } slsc_st_t;

endpackage : slsc_pkg

/* File: src/slsc_sync_filter.sv */
`timescale 1ns/1ps
`default_nettype none
`include "slsc_defs.svh"

module slsc_sync_filter
(
   // clock and reset
   input  wire logic       i_sys_clk,
   input  wire logic       i_rst,
   input  wire logic       i_clk_en,
   // sync request pin and threshold
   input  wire logic       i_sync_req_n,
   input  wire logic [4:0] i_thresh,
   // filtered results
   output logic            o_level,
   output logic            o_request,
   output logic            o_error
);

   slsc_pkg::slsc_flt_st_t q;
   slsc_pkg::slsc_flt_st_t d;

   always_comb
   begin
      d       = q;
      d.s1    = i_sync_req_n;
      d.s2    = q.s1;
      d.s3    = q.s2;
      d.error = 1'b0;
      // a pin change counts only once the two later stages agree
      if (q.s2 == q.s3)
      begin
         d.level = q.s3;
      end
      if (!q.level)
      begin
         if (q.low_cnt != `SLSC_LOWCNT_MAX)
         begin
            d.low_cnt = q.low_cnt + 6'h01;
         end
         d.request = (q.low_cnt >= {1'b0, i_thresh});
      end
      else
      begin
         d.low_cnt = 6'h00;
         d.request = 1'b0;
         // a short low run is only reported, never acted on
         d.error = (q.low_cnt != 6'h00)
                   && (q.low_cnt <= {1'b0, i_thresh});
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         q <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, level: 1'b1,
                low_cnt: 6'h00, request: 1'b0, error: 1'b0};
      end
      else if (i_clk_en)
      begin
         q <= d;
      end
   end

   assign o_level   = q.level;
   assign o_request = q.request;
   assign o_error   = q.error;

endmodule : slsc_sync_filter

`default_nettype wire

/* File: verif/slsc_rx_model.sv */
`timescale 1ns/1ps
`default_nettype none

module slsc_rx_model
(
   // clock, reset, command from the bench
   input  wire logic       i_sys_clk,
   input  wire logic       i_rst,
   input  wire logic       i_go,
   input  wire logic [7:0] i_len,
   // active-low sync pin toward the block
   output logic            o_sync_req_n
);
   logic [7:0] low_cnt_q;

   // ----------------------------------------------------------------
   // receiver request line
   // ----------------------------------------------------------------
   // short runs only appear when the bench asks for them on purpose,
   // since this receiver keeps its error reporting switched off
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
         low_cnt_q <= 8'h00;
      else if (i_go)
         low_cnt_q <= i_len;
      else if (low_cnt_q != 8'h00)
         low_cnt_q <= low_cnt_q - 8'h01;
   end

   // idle level is the pull-up, i.e. request released
   assign o_sync_req_n = (low_cnt_q == 8'h00);
endmodule : slsc_rx_model

`default_nettype wire

/* File: verif/slsc_sync_ctrl_sva.sv */
`timescale 1ns/1ps
`default_nettype none

module slsc_sync_ctrl_sva
(
   // clock and reset
   input  wire logic        i_sys_clk,
   input  wire logic        i_rst,
   input  wire logic        i_clk_en,
   // inputs watched
   input  wire logic        i_sync_req_n,
   input  wire logic        i_mb_start,
   input  wire logic [11:0] i_crc12,
   input  wire logic [25:0] i_fec,
   // outputs watched
   input  wire logic        o_send_cgs,
   input  wire logic        o_sync_request,
   input  wire logic [31:0] o_sync_word,
   input  wire logic        o_sync_word_valid
);
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_rst);

   // ----------------------------------------------------------------
   // sync word
   // ----------------------------------------------------------------
   sw_pulse_a: assert property (o_sync_word_valid && i_clk_en
      |=> !o_sync_word_valid) else $error("word valid too long");
   sw_cause_a: assert property ($rose(o_sync_word_valid)
      |-> $past(i_mb_start)) else $error("word without boundary");
   sw_idle_a: assert property (o_sync_word_valid
      |-> o_sync_word[5:0] == 6'h00) else $error("command bits set");
   sw_payload_a: assert property ($rose(o_sync_word_valid)
      |-> o_sync_word == {$past(i_crc12), 20'h0_0000}
       || o_sync_word == {$past(i_fec), 6'h00}
       || o_sync_word == 32'h0000_0000) else $error("bad payload");

   // ----------------------------------------------------------------
   // sync request filter
   // ----------------------------------------------------------------
   // last low sample that a request needs lies six ticks before its
   // rise is seen: three pin stages, filter, request and output flop
   req_cause_a: assert property ($rose(o_sync_request)
      |-> !$past(i_sync_req_n, 6)) else $error("request without low");
   req_release_a: assert property ((i_sync_req_n && i_clk_en)[*8]
      |=> !o_sync_request) else $error("request not released");
   cgs_req_a: assert property ($rose(o_send_cgs)
      |-> o_sync_request) else $error("cgs without request");
   cgs_release_a: assert property ((i_sync_req_n && i_clk_en)[*8]
      |=> !o_send_cgs) else $error("cgs not released");

   cover property ($rose(o_sync_word_valid));
   cover property ($rose(o_sync_request));
   cover property ($rose(o_send_cgs));
endmodule : slsc_sync_ctrl_sva

bind slsc_sync_ctrl slsc_sync_ctrl_sva slsc_sync_ctrl_sva_i (
   .i_sys_clk, .i_rst, .i_clk_en, .i_sync_req_n, .i_mb_start,
   .i_crc12, .i_fec, .o_send_cgs, .o_sync_request, .o_sync_word,
   .o_sync_word_valid);

`default_nettype wire

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "slsc_defs.svh"

`define CHK(g, e) \
   begin check_count++; if ((g) !== (e)) begin num_errors++; \
   $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end

module tb_top;
   localparam logic [13:0] A_CTRL = {`SLSC_IDX_CTRL, 2'b00};
   localparam logic [13:0] A_STAT = {`SLSC_IDX_STATUS, 2'b00};
   localparam logic [13:0] A_SHM  = {`SLSC_IDX_SYNC_HEADER_MODE, 2'b00};
   localparam logic [13:0] A_THR  = {`SLSC_IDX_THRESH, 2'b00};
   localparam logic [13:0] A_BAD  = 14'h0004;
   localparam logic [1:0]  OK     = `SLSC_RESP_OKAY;
   localparam logic [1:0]  ERR    = `SLSC_RESP_SLVERR;

   logic        i_sys_clk = 1'b0;
   logic        i_rst     = 1'b1;
   logic [13:0] awaddr    = 14'h0000;
   logic [13:0] araddr    = 14'h0000;
   logic [31:0] wdata     = 32'h0000_0000;
   logic        awvalid   = 1'b0;
   logic        wvalid    = 1'b0;
   logic        bready    = 1'b0;
   logic        arvalid   = 1'b0;
   logic        rready    = 1'b0;
   logic        mb        = 1'b0;
   logic        go        = 1'b0;
   logic        ce        = 1'b1;
   logic [7:0]  len       = 8'h00;
   logic [11:0] crc       = 12'h000;
   logic [25:0] fec       = 26'h000_0000;
   logic        awready, wready, bvalid, arready, rvalid;
   logic        cgs, sreq, swv, sync_n;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata, sw, rv;
   int          num_errors = 0;
   int          check_count = 0;
   // a single low sample never gets through the pin filter
   int          tv[4] = '{2, 3, 31, 0};
   int          m, seen;

   always #4 i_sys_clk = ~i_sys_clk;

   slsc_rx_model slsc_rx_model_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
      .i_go(go), .i_len(len), .o_sync_req_n(sync_n));

   slsc_sync_ctrl slsc_sync_ctrl_i (
      .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_clk_en(ce),
      .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
      .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
      .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wvalid),
      .o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
      .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
      .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
      .o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
      .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
      .i_s_axi_rready(rready), .i_sync_req_n(sync_n), .i_mb_start(mb),
      .i_crc12(crc), .i_fec(fec), .o_send_cgs(cgs),
      .o_sync_request(sreq), .o_sync_word(sw), .o_sync_word_valid(swv));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] exp_word(input int k,
      input logic [11:0] c, input logic [25:0] f);
      case (k)
         0: return {c, 20'h0_0000};
         2: return {f, 6'h00};
         default: return 32'h0000_0000;
      endcase
   endfunction : exp_word

   task automatic wr(input logic [13:0] a, input logic [31:0] d,
      input logic [1:0] er);
      @(posedge i_sys_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge i_sys_clk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end
      while (bvalid !== 1'b1);
      bready <= 1'b0;
      `CHK(bresp, er)
   endtask : wr

   task automatic rd(input logic [13:0] a, input logic [31:0] e,
      input logic [1:0] er);
      @(posedge i_sys_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge i_sys_clk);
         if (arready === 1'b1) arvalid <= 1'b0;
      end
      while (rvalid !== 1'b1);
      rready <= 1'b0;
      `CHK(rdata, e)
      `CHK(rresp, er)
   endtask : rd

   task automatic drop(input int l);
      @(posedge i_sys_clk);
      go <= 1'b1;
      len <= 8'(l);
      @(posedge i_sys_clk);
      go <= 1'b0;
   endtask : drop

   task automatic pulse(input int l, input logic e);
      drop(l);
      seen = 0;
      repeat (l + 12)
      begin
         @(posedge i_sys_clk);
         if (sreq === 1'b1) seen = 1;
      end
      `CHK(seen[0], e)
   endtask : pulse

   task automatic mbw(input logic e, input int k);
      @(posedge i_sys_clk);
      mb <= 1'b1;
      crc <= 12'($urandom);
      fec <= 26'($urandom);
      @(posedge i_sys_clk);
      mb <= 1'b0;
      #1;
      `CHK(swv, e)
      if (e) `CHK(sw, exp_word(k, crc, fec))
   endtask : mbw

   task tally_and_finish;
      if (num_errors == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : tally_and_finish

   initial
   begin
      repeat (20000) @(posedge i_sys_clk);
      num_errors++;
      tally_and_finish;
   end

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial
   begin
      rv = $urandom(36323);
      tv[3] = 2 + int'($urandom % 28);
      repeat (2) @(posedge i_sys_clk);
      i_rst <= 1'b0;
      rd(A_THR, 32'h0000_0003, OK);
      rd(A_SHM, 32'h0000_0000, OK);
      rd(A_STAT, 32'h0000_0001, OK);
      rd(A_BAD, 32'h0000_0000, ERR);
      wr(A_BAD, 32'h0000_0001, ERR);
      // a run of exactly the threshold is only an error report
      for (int i = 0; i < 4; i++)
      begin
         wr(A_THR, 32'(tv[i]), OK);
         rd(A_THR, 32'(tv[i]), OK);
         wr(A_STAT, 32'h0000_0000, OK);
         pulse(tv[i], 1'b0);
         rd(A_STAT, 32'h0000_0101, OK);
         pulse(tv[i] + 1, 1'b1);
      end
      wr(A_THR, 32'h0000_0000, OK);
      wr(A_CTRL, 32'h0000_0001, OK);
      drop(40);
      repeat (10) @(posedge i_sys_clk);
      `CHK(cgs, 1'b1)
      rd(A_STAT, 32'h0000_0106, OK);
      repeat (45) @(posedge i_sys_clk);
      `CHK(cgs, 1'b0)
      for (m = 0; m < 4; m++)
      begin
         wr(A_CTRL, 32'h0000_0000, OK);
         wr(A_SHM, 32'(m), OK);
         rd(A_SHM, 32'(m), OK);
         wr(A_CTRL, 32'h0000_0081, OK);
         mbw(1'b1, m);
      end
      // a frozen block lets a boundary pass unseen
      @(posedge i_sys_clk);
      ce <= 1'b0;
      mbw(1'b0, 3);
      @(posedge i_sys_clk);
      ce <= 1'b1;
      wr(A_CTRL, 32'h0000_0001, OK);
      mbw(1'b0, 3);
      tally_and_finish;
   end
endmodule : tb_top

`default_nettype wire
